/* File: core/jtag_tap_controller.sv */
// Purpose: Test access port with instruction, bypass, identification and boundary chains.
// Assumes: ref_clk is at least eight times the test clock; pins are sampled, not clocked on.
// Notes:   Pin configuration registers sit behind an AHB-Lite slave with no wait states.
//
// Design decisions made here: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
// What this block does
// - State advances on the mode-select level sampled at each rising test clock edge.
// - The state decides capture, shift, update and instruction versus data access.
// - The held instruction picks which data chain the data states act on.
// - External and internal test instructions capture and shift only the bypass bit, never the boundary chain.
// - Unimplemented instruction codes decode as bypass so a serial path always exists.
// - Power-on reset clears everything; the external reset restores pin setup only.
// - After reset input pins pull up, no pull down; output pulls up, undriven.
// - A stopped test clock freezes state, chains and held registers; pin setup still takes bus writes.
// - A sampled input bit enters the selected shifting chain, else it is dropped.
// - Serial output follows state, instruction and chain, changing on falling edges.
// - The serial output driver is off whenever no shifting is in progress.
// - Five rising edges with mode-select high reach Test-Logic-Reset from anywhere.
// - Entering Test-Logic-Reset returns all chains and the held instruction and boundary data to defaults.
// - Power-on reset puts the state machine directly into Test-Logic-Reset.
// - Shared pins leave reset assigned to the test function, alternate select set.
// - Mux field encoding three gives a shared pin to the test function.
// - Moving test pins to general use through alternate select needs unlock and commit first; the mux field needs neither.
// - The instruction chain is four bits wide and holds the loaded instruction.
// - Core instructions route the core controller's output except in Shift-IR; others route ours.
// - Chains capture in capture states, shift while shifting, update in update states.
module jtag_tap_controller
  import jtag_pkg::*;
#(
  // Arbitrary identification value.
  parameter logic [31:0] ID_VALUE = 32'h1234_5679
)(
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              extRstN,
  input  wire logic              tckPin,
  input  wire logic              tmsPin,
  input  wire logic              tdiPin,
  input  wire logic              coreTdo,
  input  wire logic [BSR_W-1:0]  bsrIn,
  output logic                   tdoOut,
  output logic                   tdoOe,
  output logic [PIN_N-1:0]       pullUpEn,
  output logic [PIN_N-1:0]       pullDownEn,
  output logic [PIN_N-1:0]       digitalEn,
  output logic [PIN_N-1:0]       pinIsJtag,
  output logic                   coreSelect,
  output logic [BSR_W-1:0]       bsrOut,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata
);
  typedef struct packed {
    logic [1:0]       tckSync;
    logic [1:0]       tmsSync;
    logic [1:0]       tdiSync;
    logic [1:0]       rstSync;
    logic             tckLast;
    logic [IR_W-1:0]  irShift;
    logic [IR_W-1:0]  irHold;
    logic             bypassBit;
    logic [31:0]      idShift;
    logic [BSR_W-1:0] bsrShift;
    logic [BSR_W-1:0] bsrHold;
    logic             tdo;
    logic             tdoOe;
    logic             wrPend;
    logic [7:0]       wrAddr;
    logic [31:0]      rdata;
  } ctl_t;

  ctl_t      ctl_r;
  ctl_t      ctl_nxt;
  logic      tckEff;
  logic      tmsEff;
  logic      tdiEff;
  logic      tckRise;
  logic      tckFall;
  chainSel_t chain;
  logic      addrTaken;
  logic [7:0] addrLow;

  jtag_link_if lnk ();

  tap_fsm u_fsm (
    .ref_clk (ref_clk),
    .rst     (rst),
    .lnk     (lnk.fsmSide)
  );

  pin_config u_cfg (
    .ref_clk (ref_clk),
    .rst     (rst),
    .lnk     (lnk.cfgSide)
  );

  function automatic chainSel_t decodeIns(input logic [IR_W-1:0] ins);
    unique case (ins)
      INS_IDCODE:                       decodeIns = CH_IDCODE;
      INS_SAMPLE:                       decodeIns = CH_BSR;
      INS_ABORT, INS_DPACC, INS_APACC:  decodeIns = CH_CORE;
      // Test instructions work on held data, so only the bypass bit moves.
      INS_EXTEST, INS_INTEST:           decodeIns = CH_BYPASS;
      default:                          decodeIns = CH_BYPASS;
    endcase
  endfunction

  // A pin handed to general use reads as its idle pull-up level here.
  always_comb
  begin
    for (int i = 0; i < PIN_N; i++)
    begin
      pinIsJtag[i] = lnk.altFn[i] && (lnk.pctl[i*PMC_W +: PMC_W] == PMC_JTAG);
    end
  end

  assign tckEff  = ctl_r.tckSync[1] | ~pinIsJtag[0];
  assign tmsEff  = ctl_r.tmsSync[1] | ~pinIsJtag[1];
  assign tdiEff  = ctl_r.tdiSync[1] | ~pinIsJtag[2];
  assign tckRise = tckEff & ~ctl_r.tckLast;
  assign tckFall = ~tckEff & ctl_r.tckLast;
  assign chain   = decodeIns(ctl_r.irHold);

  assign addrLow   = haddr[7:0];
  assign addrTaken = hsel && hready && htrans[1];

  assign lnk.tckRise  = tckRise;
  assign lnk.tmsBit   = tmsEff;
  assign lnk.pinReset = ~ctl_r.rstSync[1];
  assign lnk.wrEn     = ctl_r.wrPend;
  assign lnk.wrAddr   = ctl_r.wrAddr;
  assign lnk.wrData   = hwdata;

  always_comb
  begin
    ctl_nxt = ctl_r;
    ctl_nxt.tckSync = {ctl_r.tckSync[0], tckPin};
    ctl_nxt.tmsSync = {ctl_r.tmsSync[0], tmsPin};
    ctl_nxt.tdiSync = {ctl_r.tdiSync[0], tdiPin};
    ctl_nxt.rstSync = {ctl_r.rstSync[0], extRstN};
    ctl_nxt.tckLast = tckEff;
    if (tckRise)
    begin
      unique case (lnk.state)
        // Select-IR with mode high is the only way in, so defaults land on the entering edge
        // and a test clock stopped right after entry still finds them in place.
        TAP_RESET, TAP_SEL_IR:
        begin
          if (lnk.state == TAP_RESET || tmsEff)
          begin
            ctl_nxt.irShift   = IR_CAPTURE;
            ctl_nxt.irHold    = INS_IDCODE;
            ctl_nxt.bypassBit = 1'b0;
            ctl_nxt.idShift   = ID_VALUE;
            ctl_nxt.bsrShift  = '0;
            ctl_nxt.bsrHold   = '0;
          end
        end
        TAP_CAP_IR:   ctl_nxt.irShift = IR_CAPTURE;
        TAP_SHIFT_IR: ctl_nxt.irShift = {tdiEff, ctl_r.irShift[IR_W-1:1]};
        TAP_UPD_IR:   ctl_nxt.irHold = ctl_r.irShift;
        TAP_CAP_DR:
        begin
          unique case (chain)
            CH_BYPASS: ctl_nxt.bypassBit = 1'b0;
            CH_IDCODE: ctl_nxt.idShift = ID_VALUE;
            CH_BSR:    ctl_nxt.bsrShift = bsrIn;
            CH_CORE:   ctl_nxt.bypassBit = ctl_r.bypassBit;
          endcase
        end
        TAP_SHIFT_DR:
        begin
          unique case (chain)
            CH_BYPASS: ctl_nxt.bypassBit = tdiEff;
            CH_IDCODE: ctl_nxt.idShift = {tdiEff, ctl_r.idShift[31:1]};
            CH_BSR:    ctl_nxt.bsrShift = {tdiEff, ctl_r.bsrShift[BSR_W-1:1]};
            CH_CORE:   ctl_nxt.bypassBit = ctl_r.bypassBit;
          endcase
        end
        TAP_UPD_DR:
        begin
          if (chain == CH_BSR)
          begin
            ctl_nxt.bsrHold = ctl_r.bsrShift;
          end
        end
        default:      ctl_nxt.irHold = ctl_r.irHold;
      endcase
    end
    if (tckFall)
    begin
      ctl_nxt.tdoOe = (lnk.state == TAP_SHIFT_IR) || (lnk.state == TAP_SHIFT_DR);
      if (lnk.state == TAP_SHIFT_IR)
      begin
        ctl_nxt.tdo = ctl_r.irShift[0];
      end
      else
      begin
        unique case (chain)
          CH_BYPASS: ctl_nxt.tdo = ctl_r.bypassBit;
          CH_IDCODE: ctl_nxt.tdo = ctl_r.idShift[0];
          CH_BSR:    ctl_nxt.tdo = ctl_r.bsrShift[0];
          CH_CORE:   ctl_nxt.tdo = coreTdo;
        endcase
      end
    end
    // Bus side: register the write for its data phase, read data for the next cycle.
    ctl_nxt.wrPend = addrTaken && hwrite;
    if (addrTaken)
    begin
      ctl_nxt.wrAddr = addrLow;
      ctl_nxt.rdata  = '0;
      if (!hwrite && haddr[31:8] == 24'h0)
      begin
        unique case (addrLow)
          OFS_ALTFN:  ctl_nxt.rdata = 32'(lnk.altFn);
          OFS_PUR:    ctl_nxt.rdata = 32'(lnk.pur);
          OFS_PDR:    ctl_nxt.rdata = 32'(lnk.pdr);
          OFS_DEN:    ctl_nxt.rdata = 32'(lnk.den);
          OFS_LOCK:   ctl_nxt.rdata = 32'(lnk.locked);
          OFS_COMMIT: ctl_nxt.rdata = 32'(lnk.commit);
          OFS_PCTL:   ctl_nxt.rdata = 32'(lnk.pctl);
          OFS_BSR:    ctl_nxt.rdata = 32'(ctl_r.bsrHold);
          OFS_STATUS:
          begin
            ctl_nxt.rdata[ST_STATE_LSB +: 4] = lnk.state;
            ctl_nxt.rdata[ST_IR_LSB +: IR_W] = ctl_r.irHold;
            ctl_nxt.rdata[ST_OE_BIT]         = ctl_r.tdoOe;
            ctl_nxt.rdata[ST_LOCK_BIT]       = lnk.locked;
          end
          default:    ctl_nxt.rdata = '0;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      ctl_r <= '{tckSync: 2'h3, tmsSync: 2'h3, tdiSync: 2'h3, rstSync: 2'h3, tckLast: 1'b1,
                 irShift: IR_CAPTURE, irHold: INS_IDCODE, bypassBit: 1'b0, idShift: ID_VALUE,
                 bsrShift: '0, bsrHold: '0, tdo: 1'b0, tdoOe: 1'b0, wrPend: 1'b0,
                 wrAddr: 8'h00, rdata: 32'h0000_0000};
    end
    else
    begin
      ctl_r <= ctl_nxt;
    end
  end

  assign tdoOut     = ctl_r.tdo;
  assign tdoOe      = ctl_r.tdoOe & pinIsJtag[3];
  assign pullUpEn   = lnk.pur;
  assign pullDownEn = lnk.pdr;
  assign digitalEn  = lnk.den;
  assign coreSelect = (chain == CH_CORE);
  assign bsrOut     = ctl_r.bsrHold;
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign hrdata     = ctl_r.rdata;

  // Counts rising edges seen with mode select high; used only by a check below.
  logic [2:0] onesCnt;
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      onesCnt <= 3'h0;
    end
    else if (tckRise)
    begin
      onesCnt <= tmsEff ? ((onesCnt == 3'h5) ? 3'h5 : onesCnt + 3'h1) : 3'h0;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence shiftIrEdge;
    tckRise && lnk.state == TAP_SHIFT_IR;
  endsequence

  sequence updIrEdge;
    tckRise && lnk.state == TAP_UPD_IR;
  endsequence

  porEntry_a: assert property (disable iff (1'b0) rst |=> lnk.state == TAP_RESET)
    else $error("power-on reset did not reach reset state");
  fiveOnes_a: assert property (onesCnt == 3'h5 |-> lnk.state == TAP_RESET)
    else $error("five high mode samples did not reach reset state");
  stoppedClock_a: assert property (!tckRise |=> $stable(lnk.state) && $stable(ctl_r.irHold))
    else $error("state changed without a test clock edge");
  resetDefault_a: assert property (tckRise && lnk.state == TAP_RESET |=>
                                   ctl_r.irHold == INS_IDCODE && ctl_r.bsrHold == '0)
    else $error("reset state did not restore defaults");
  resetEntry_a: assert property (tckRise && lnk.state == TAP_SEL_IR && tmsEff
                                 |=> ctl_r.irHold == INS_IDCODE && ctl_r.bypassBit == 1'b0)
    else $error("entering reset state did not restore defaults");
  irShiftIn_a: assert property (shiftIrEdge |=> ctl_r.irShift[IR_W-1] == $past(tdiEff))
    else $error("data input bit did not enter instruction chain");
  irUpdate_a: assert property (updIrEdge |=> ctl_r.irHold == $past(ctl_r.irShift))
    else $error("instruction update lost");
  tdoFallOnly_a: assert property (!tckFall |=> $stable(ctl_r.tdo))
    else $error("serial output changed off a falling edge");
  tdoIdle_a: assert property (tckFall && lnk.state != TAP_SHIFT_IR &&
                              lnk.state != TAP_SHIFT_DR |=> !tdoOe)
    else $error("serial output driven outside shifting");
  bypassPath_a: assert property (tckRise && lnk.state == TAP_SHIFT_DR && chain == CH_BYPASS
                                 |=> ctl_r.bypassBit == $past(tdiEff))
    else $error("bypass path broken");
  testHold_a: assert property (ctl_r.irHold == INS_EXTEST || ctl_r.irHold == INS_INTEST
                               |=> $stable(ctl_r.bsrShift) || $past(lnk.state) == TAP_UPD_IR
                                   || $past(lnk.state) == TAP_RESET)
    else $error("test instruction moved a chain");
  pinDefault_a: assert property (disable iff (1'b0) rst |=> pullUpEn == PUR_RST
                                 && pullDownEn == PDR_RST && pinIsJtag == 4'hF)
    else $error("pins not in test configuration after reset");

endmodule // jtag_tap_controller

/* File: core/jtag_pkg.sv */
// Purpose: Shared constants and types for the test access port block.
// Assumes: One 40 MHz system clock samples the test clock pin.
// Notes:   Pin index 0 is the test clock, 1 mode select, 2 data in, 3 data out.
package jtag_pkg;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE,
    TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR, TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR,
    TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } tapState_t;

  typedef enum logic [1:0] {CH_BYPASS, CH_IDCODE, CH_BSR, CH_CORE} chainSel_t;

  localparam int          IR_W         = 4;
  localparam int          BSR_W        = 8;
  localparam int          PIN_N        = 4;
  localparam int          PMC_W        = 4;

  localparam logic [3:0]  INS_EXTEST   = 4'h0;
  localparam logic [3:0]  INS_INTEST   = 4'h1;
  localparam logic [3:0]  INS_SAMPLE   = 4'h2;
  localparam logic [3:0]  INS_ABORT    = 4'h8;
  localparam logic [3:0]  INS_DPACC    = 4'hA;
  localparam logic [3:0]  INS_APACC    = 4'hB;
  localparam logic [3:0]  INS_IDCODE   = 4'hE;
  localparam logic [3:0]  INS_BYPASS   = 4'hF;
  localparam logic [3:0]  IR_CAPTURE   = 4'h1;

  localparam logic [7:0]  OFS_ALTFN    = 8'h00;
  localparam logic [7:0]  OFS_PUR      = 8'h04;
  localparam logic [7:0]  OFS_PDR      = 8'h08;
  localparam logic [7:0]  OFS_DEN      = 8'h0C;
  localparam logic [7:0]  OFS_LOCK     = 8'h10;
  localparam logic [7:0]  OFS_COMMIT   = 8'h14;
  localparam logic [7:0]  OFS_PCTL     = 8'h18;
  localparam logic [7:0]  OFS_STATUS   = 8'h1C;
  localparam logic [7:0]  OFS_BSR      = 8'h20;

  localparam int          ST_STATE_LSB = 0;
  localparam int          ST_IR_LSB    = 4;
  localparam int          ST_OE_BIT    = 8;
  localparam int          ST_LOCK_BIT  = 9;

  localparam logic [3:0]  ALTFN_RST    = 4'hF;
  localparam logic [3:0]  PUR_RST      = 4'hF;
  localparam logic [3:0]  PDR_RST      = 4'h0;
  localparam logic [3:0]  DEN_RST      = 4'hF;
  localparam logic [3:0]  COMMIT_RST   = 4'h0;
  localparam logic [3:0]  PMC_JTAG     = 4'h3;
  localparam logic [15:0] PCTL_RST     = 16'h3333;
  // Arbitrary unlock key value.
  localparam logic [31:0] LOCK_KEY     = 32'h5A5A_C3C3;

endpackage

/* File: core/jtag_link_if.sv */
// Purpose: Carries state machine and pin configuration signals inside the block.
// Assumes: All signals live in the ref_clk domain.
// Notes:   The top module holds the user modports.
`timescale 1ns/1ps
interface jtag_link_if;
  import jtag_pkg::*;
  logic                    tckRise;
  logic                    tmsBit;
  tapState_t               state;
  logic                    pinReset;
  logic                    wrEn;
  logic [7:0]              wrAddr;
  logic [31:0]             wrData;
  logic [PIN_N-1:0]        altFn;
  logic [PIN_N-1:0]        pur;
  logic [PIN_N-1:0]        pdr;
  logic [PIN_N-1:0]        den;
  logic [PIN_N-1:0]        commit;
  logic [PIN_N*PMC_W-1:0]  pctl;
  logic                    locked;
  modport fsmSide (input tckRise, input tmsBit, output state);
  modport cfgSide (input pinReset, input wrEn, input wrAddr, input wrData,
                   output altFn, output pur, output pdr, output den,
                   output commit, output pctl, output locked);
endinterface

/* File: core/tap_fsm.sv */
// Purpose: Sixteen state test access port sequencer.
// Assumes: tckRise is a one cycle pulse per test clock rising edge.
// Notes:   Advances only on tckRise, so a stopped test clock freezes it.
`timescale 1ns/1ps
module tap_fsm
  import jtag_pkg::*;
(
  input wire logic     ref_clk,
  input wire logic     rst,
  jtag_link_if.fsmSide lnk
);
  typedef struct packed {
    tapState_t st;
  } fsm_t;

  fsm_t fsm_r;
  fsm_t fsm_nxt;

  function automatic tapState_t tapNext(input tapState_t s, input logic tms);
    unique case (s)
      TAP_RESET:    tapNext = tms ? TAP_RESET    : TAP_IDLE;
      TAP_IDLE:     tapNext = tms ? TAP_SEL_DR   : TAP_IDLE;
      TAP_SEL_DR:   tapNext = tms ? TAP_SEL_IR   : TAP_CAP_DR;
      TAP_CAP_DR:   tapNext = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: tapNext = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: tapNext = tms ? TAP_UPD_DR   : TAP_PAUSE_DR;
      TAP_PAUSE_DR: tapNext = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: tapNext = tms ? TAP_UPD_DR   : TAP_SHIFT_DR;
      TAP_UPD_DR:   tapNext = tms ? TAP_SEL_DR   : TAP_IDLE;
      TAP_SEL_IR:   tapNext = tms ? TAP_RESET    : TAP_CAP_IR;
      TAP_CAP_IR:   tapNext = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: tapNext = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: tapNext = tms ? TAP_UPD_IR   : TAP_PAUSE_IR;
      TAP_PAUSE_IR: tapNext = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: tapNext = tms ? TAP_UPD_IR   : TAP_SHIFT_IR;
      TAP_UPD_IR:   tapNext = tms ? TAP_SEL_DR   : TAP_IDLE;
    endcase
  endfunction

  always_comb
  begin
    fsm_nxt = fsm_r;
    if (lnk.tckRise)
    begin
      fsm_nxt.st = tapNext(fsm_r.st, lnk.tmsBit);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      fsm_r <= '{st: TAP_RESET};
    end
    else
    begin
      fsm_r <= fsm_nxt;
    end
  end

  assign lnk.state = fsm_r.st;

endmodule // tap_fsm

/* File: core/pin_config.sv */
// Purpose: Pin function, pull and commit protection registers for the four test pins.
// Assumes: Writes arrive as one cycle strobes from the bus slave.
// Notes:   Alternate select, pulls and digital enable only change on committed bits; the mux field is unguarded.
`timescale 1ns/1ps
module pin_config
  import jtag_pkg::*;
(
  input wire logic     ref_clk,
  input wire logic     rst,
  jtag_link_if.cfgSide lnk
);
  typedef struct packed {
    logic [PIN_N-1:0]       altFn;
    logic [PIN_N-1:0]       pur;
    logic [PIN_N-1:0]       pdr;
    logic [PIN_N-1:0]       den;
    logic [PIN_N-1:0]       commit;
    logic [PIN_N*PMC_W-1:0] pctl;
    logic                   locked;
  } cfg_t;

  cfg_t cfg_r;
  cfg_t cfg_nxt;

  // Only committed bits take the new value; the rest keep their old value.
  function automatic logic [PIN_N-1:0] guarded(input logic [PIN_N-1:0] old,
                                               input logic [PIN_N-1:0] val,
                                               input logic [PIN_N-1:0] mask);
    guarded = (old & ~mask) | (val & mask);
  endfunction

  always_comb
  begin
    cfg_nxt = cfg_r;
    if (lnk.wrEn)
    begin
      unique case (lnk.wrAddr)
        OFS_ALTFN:  cfg_nxt.altFn = guarded(cfg_r.altFn, lnk.wrData[3:0], cfg_r.commit);
        OFS_PUR:    cfg_nxt.pur = guarded(cfg_r.pur, lnk.wrData[3:0], cfg_r.commit);
        OFS_PDR:    cfg_nxt.pdr = guarded(cfg_r.pdr, lnk.wrData[3:0], cfg_r.commit);
        OFS_DEN:    cfg_nxt.den = guarded(cfg_r.den, lnk.wrData[3:0], cfg_r.commit);
        OFS_LOCK:   cfg_nxt.locked = (lnk.wrData != LOCK_KEY);
        OFS_COMMIT: cfg_nxt.commit = cfg_r.locked ? cfg_r.commit : lnk.wrData[3:0];
        OFS_PCTL:   cfg_nxt.pctl = lnk.wrData[15:0];
        default:    cfg_nxt = cfg_r;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst || lnk.pinReset)
    begin
      cfg_r <= '{altFn: ALTFN_RST, pur: PUR_RST, pdr: PDR_RST, den: DEN_RST,
                 commit: COMMIT_RST, pctl: PCTL_RST, locked: 1'b1};
    end
    else
    begin
      cfg_r <= cfg_nxt;
    end
  end

  assign lnk.altFn  = cfg_r.altFn;
  assign lnk.pur    = cfg_r.pur;
  assign lnk.pdr    = cfg_r.pdr;
  assign lnk.den    = cfg_r.den;
  assign lnk.commit = cfg_r.commit;
  assign lnk.pctl   = cfg_r.pctl;
  assign lnk.locked = cfg_r.locked;

endmodule // pin_config

/* File: verification/jtag_probe.sv */
// Purpose: Test probe model that drives the test pins of the port.
// Assumes: 200 ns test clock; the clock stands high between frames.
// Notes:   Mode and data change at the falling edge, data out is read late in the high phase.
`timescale 1ns/1ps
module jtag_probe (
  output logic      tckPin,
  output logic      tmsPin,
  output logic      tdiPin,
  input  wire logic tdoOut,
  input  wire logic tdoOe
);
  initial
  begin
    tckPin = 1'b1;
    tmsPin = 1'b1;
    tdiPin = 1'b1;
  end

  task automatic step(input logic m, input logic d, output logic o, output logic e);
    tckPin <= 1'b0;
    tmsPin <= m;
    tdiPin <= d;
    #100 tckPin <= 1'b1;
    #90 o = tdoOe ? tdoOut : 1'b1;
    e = tdoOe;
    #10;
  endtask

  // Mode bits are sent LSB first; data in rests high, as its pull-up would leave it.
  task automatic walk(input logic [7:0] t, input int n);
    logic o, e;
    #3;
    for (int i = 0; i < n; i++) step(t[i], 1'b1, o, e);
  endtask

  task automatic scan(input logic ir, input int n, input logic [31:0] d,
                      output logic [31:0] q, output logic oe);
    logic o, e;
    q  = '0;
    oe = 1'b1;
    walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, d[i], o, e);
      q[i] = o;
      oe   = oe & e;
    end
    walk(8'h01, 2);
  endtask
endmodule // jtag_probe

/* File: verification/jtag_tap_controller_tb.sv */
// Purpose: Self-checking bench for the test access port block.
// Assumes: Zero wait state bus slave; the probe model drives the test pins.
// Notes:   Scans start from Run-Test/Idle and end there.
`timescale 1ns/1ps
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, a); end end
module jtag_tap_controller_tb;
  import jtag_pkg::*;
  // Arbitrary identification value.
  localparam logic [31:0] IDV = 32'hC0DE_0001;
  logic             ref_clk, rst, extRstN, tckPin, tmsPin, tdiPin, coreTdo, tdoOut, tdoOe;
  logic             coreSelect, hsel, hwrite, hreadyout, hresp, oe;
  logic [7:0]       bsrIn, bsrOut;
  logic [PIN_N-1:0] pullUpEn, pullDownEn, digitalEn, pinIsJtag;
  logic [31:0]      haddr, hwdata, hrdata, rd, so;
  logic [1:0]       htrans;
  int               n_mismatch, check_count, cyc;

  jtag_tap_controller #(.ID_VALUE(IDV)) i_jtag_tap_controller (.ref_clk, .rst, .extRstN,
    .tckPin, .tmsPin, .tdiPin, .coreTdo, .bsrIn, .tdoOut, .tdoOe, .pullUpEn, .pullDownEn,
    .digitalEn, .pinIsJtag, .coreSelect, .bsrOut, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'b010), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata);
  jtag_probe i_jtag_probe (.tckPin, .tmsPin, .tdiPin, .tdoOut, .tdoOe);

  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge ref_clk);
    hsel   <= 1'b1;
    hwrite <= w;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    q = hrdata;
    hsel <= 1'b0;
  endtask

  task automatic status(input logic [3:0] st, input logic [3:0] ins);
    bus(1'b0, OFS_STATUS, 32'h0, rd);
    `CHK("state", st, rd[ST_STATE_LSB +: 4])
    `CHK("held", ins, rd[ST_IR_LSB +: 4])
  endtask

  task automatic ir(input logic [3:0] c);
    i_jtag_probe.scan(1'b1, 4, {28'h0, c}, so, oe);
    `CHK("irCap", IR_CAPTURE, so[3:0])
    status(TAP_IDLE, c);
  endtask

  task automatic t_reset;
    `CHK("pullUp", 4'hF, pullUpEn)
    `CHK("pullDown", 4'h0, pullDownEn)
    `CHK("digEn", 4'hF, digitalEn)
    `CHK("owned", 4'hF, pinIsJtag)
    `CHK("tdoOe", 1'b0, tdoOe)
    `CHK("hresp", 1'b0, hresp)
    `CHK("hready", 1'b1, hreadyout)
    status(TAP_RESET, INS_IDCODE);
  endtask

  task automatic t_idcode;
    i_jtag_probe.walk(8'h1F, 6);
    i_jtag_probe.scan(1'b0, 32, 32'h0, so, oe);
    `CHK("idcode", IDV, so)
    `CHK("oeShift", 1'b1, oe)
    `CHK("oeIdle", 1'b0, tdoOe)
  endtask

  // Unimplemented and test-only codes must all give a one-bit path that captures zero.
  task automatic t_bypass;
    logic [3:0] c [4] = '{4'h5, INS_INTEST, INS_EXTEST, INS_BYPASS};
    logic [7:0] b0;
    b0 = bsrOut;
    foreach (c[i])
    begin
      ir(c[i]);
      i_jtag_probe.scan(1'b0, 8, 32'hA5, so, oe);
      `CHK("bypass", 8'h4A, so[7:0])
      `CHK("bsrKept", b0, bsrOut)
    end
  endtask

  task automatic t_sample;
    bsrIn <= 8'h3C;
    ir(INS_SAMPLE);
    i_jtag_probe.scan(1'b0, 8, 32'hC5, so, oe);
    `CHK("bsrCap", 8'h3C, so[7:0])
    `CHK("bsrUpd", 8'hC5, bsrOut)
    bus(1'b0, OFS_BSR, 32'h0, rd);
    `CHK("bsrReg", 32'hC5, rd)
  endtask

  task automatic t_core;
    logic [3:0] c [3] = '{INS_ABORT, INS_DPACC, INS_APACC};
    coreTdo <= 1'b1;
    foreach (c[i])
    begin
      ir(c[i]);
      `CHK("coreSel", 1'b1, coreSelect)
      i_jtag_probe.scan(1'b0, 4, 32'h0, so, oe);
      `CHK("coreTdo", 4'hF, so[3:0])
    end
    ir(INS_IDCODE);
    `CHK("ownSel", 1'b0, coreSelect)
    coreTdo <= 1'b0;
  endtask

  task automatic t_freeze;
    ir(INS_SAMPLE);
    i_jtag_probe.walk(8'h01, 3);
    repeat (300) @(posedge ref_clk);
    status(TAP_SHIFT_DR, INS_SAMPLE);
    i_jtag_probe.walk(8'h1F, 5);
    status(TAP_RESET, INS_IDCODE);
    i_jtag_probe.walk(8'h00, 1);
  endtask

  task automatic t_pins;
    ir(INS_SAMPLE);
    bus(1'b1, OFS_PCTL, 32'h3303, rd);
    @(negedge ref_clk);
    `CHK("pctl", 4'hD, pinIsJtag)
    bus(1'b1, OFS_ALTFN, 32'h0, rd);
    @(negedge ref_clk);
    `CHK("locked", 4'hD, pinIsJtag)
    bus(1'b1, OFS_LOCK, LOCK_KEY, rd);
    bus(1'b1, OFS_COMMIT, 32'hF, rd);
    bus(1'b1, OFS_ALTFN, 32'h0, rd);
    @(negedge ref_clk);
    `CHK("commit", 4'h0, pinIsJtag)
    bus(1'b1, OFS_PUR, 32'h0, rd);
    @(negedge ref_clk);
    `CHK("pur", 4'h0, pullUpEn)
    bus(1'b0, 8'h40, 32'h0, rd);
    `CHK("unmapped", 32'h0, rd)
    extRstN <= 1'b0;
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    `CHK("extOwned", 4'hF, pinIsJtag)
    `CHK("extPull", 4'hF, pullUpEn)
    status(TAP_IDLE, INS_SAMPLE);
    extRstN <= 1'b1;
  endtask

  task automatic t_por;
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    status(TAP_RESET, INS_IDCODE);
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // The whole run needs under 5000 cycles, so this only trips on a hang.
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      conclude;
    end
  end

  initial
  begin
    {rst, extRstN, coreTdo, hsel, hwrite} = 5'b11000;
    {bsrIn, htrans, haddr, hwdata} = '0;
    {n_mismatch, check_count, cyc} = '0;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_reset;
    t_idcode;
    t_bypass;
    t_sample;
    t_core;
    t_freeze;
    t_pins;
    t_por;
    conclude;
  end
endmodule // jtag_tap_controller_tb
